//--- core/srp_pin_sync.sv
`timescale 1ns/1ns
module srp_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             resetn,   // Async reset, active low
  input  wire logic [WIDTH-1:0] pinIn,    // Raw pin levels
  output logic      [WIDTH-1:0] pinOut    // Filtered levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } srp_sync_t;

  srp_sync_t state_reg;
  srp_sync_t state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = pinIn;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // Only accept a change once two later stages agree
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.q[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinOut = state_reg.q;
endmodule

//--- core/srp_status_regs.sv
`timescale 1ns/1ns
module srp_status_regs (
  input  wire logic        clk_sys,          // System clock, 10 MHz
  input  wire logic        resetn,           // Async reset, active low
  input  wire logic [3:0]  bankSel,          // Selected register bank
  input  wire logic [3:0]  regAddr,          // Register offset in bank
  input  wire logic        regWrEn,          // Register write strobe
  input  wire logic        regRdEn,          // Register read strobe
  input  wire logic [15:0] regWrData,        // Write data
  output logic      [15:0] regRdData,        // Read data
  output logic             regRdValid,       // Read data valid pulse
  input  wire logic        txSelftestDone,   // Transmit memory test finished
  input  wire logic        txSelftestFail,   // Transmit memory test failed
  input  wire logic        rxSelftestDone,   // Receive memory test finished
  input  wire logic        rxSelftestFail,   // Receive memory test failed
  input  wire logic        eepromPresentPin, // EEPROM fitted pin
  input  wire logic        cfgWordValid,     // Config word strobe from loader
  input  wire logic [7:0]  cfgWordAddr,      // Address of loaded word
  input  wire logic [15:0] cfgWord,          // Loaded word
  input  wire logic        wakeEvent,        // Wake signal from matcher
  input  wire logic [1:0]  powerState,       // Current power state
  input  wire logic        powerEventEnable, // Power event enable
  output logic             coreResetN,       // Reset to core, active low
  output logic             powerEventOutN    // Power event pin, active low
);
  typedef struct packed {
    logic        txDone;
    logic        txFail;
    logic        rxDone;
    logic        rxFail;
    logic        softReset;
    logic        wakeS2;
    logic        wakeS1;
    logic        supS2;
    logic        supS1;
    logic        wideBus;
    logic [15:0] rdData;
    logic        rdValid;
    logic        coreRstN;
  } srp_regs_t;

  srp_regs_t   state_reg;
  srp_regs_t   state_next;
  logic        eepromPresent;
  logic        bankHit;
  logic [15:0] infoWord;
  logic [15:0] capWord;

  srp_pin_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pinIn   (eepromPresentPin),
    .pinOut  (eepromPresent)
  );

  srp_wake_gate u_wake_gate (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .wakeEvent        (wakeEvent),
    .powerState       (powerState),
    .powerEventEnable (powerEventEnable),
    .capWakeS1        (state_reg.wakeS1),
    .capWakeS2        (state_reg.wakeS2),
    .powerEventOutN   (powerEventOutN)
  );

  assign bankHit = (bankSel == srp_pkg::BANK_SEL);

  always_comb begin
    infoWord = '0;
    infoWord[srp_pkg::TX_DONE_BIT] = state_reg.txDone;
    infoWord[srp_pkg::TX_FAIL_BIT] = state_reg.txFail;
    infoWord[srp_pkg::RX_DONE_BIT] = state_reg.rxDone;
    infoWord[srp_pkg::RX_FAIL_BIT] = state_reg.rxFail;
    capWord = '0;
    capWord[srp_pkg::CAP_WAKE_COLD3_BIT] = srp_pkg::CAP_WAKE_COLD3_VAL;
    capWord[srp_pkg::CAP_WAKE_HOT3_BIT]  = srp_pkg::CAP_WAKE_HOT3_VAL;
    capWord[srp_pkg::CAP_WAKE_S2_BIT]    = state_reg.wakeS2;
    capWord[srp_pkg::CAP_WAKE_S1_BIT]    = state_reg.wakeS1;
    capWord[srp_pkg::CAP_WAKE_S0_BIT]    = srp_pkg::CAP_WAKE_S0_VAL;
    capWord[srp_pkg::CAP_S2_SUP_BIT]     = state_reg.supS2;
    capWord[srp_pkg::CAP_S1_SUP_BIT]     = state_reg.supS1;
    capWord[srp_pkg::CAP_WIDE_BUS_BIT]   = state_reg.wideBus;
  end

  always_comb begin
    state_next = state_reg;
    // Sticky until hardware reset; soft reset leaves results readable
    if (txSelftestDone) begin
      state_next.txDone = 1'b1;
      if (txSelftestFail) begin
        state_next.txFail = 1'b1;
      end
    end
    if (rxSelftestDone) begin
      state_next.rxDone = 1'b1;
      if (rxSelftestFail) begin
        state_next.rxFail = 1'b1;
      end
    end
    if (regWrEn && bankHit && regAddr == srp_pkg::SOFT_RESET_OFF) begin
      state_next.softReset = regWrData[srp_pkg::SOFT_RESET_BIT];
    end
    // Loader words are ignored without a fitted EEPROM, fields stay zero
    if (cfgWordValid && eepromPresent && cfgWordAddr == srp_pkg::CFG_WORD_ADDR) begin
      state_next.wakeS2  = cfgWord[srp_pkg::CFG_WAKE_S2_BIT];
      state_next.wakeS1  = cfgWord[srp_pkg::CFG_WAKE_S1_BIT];
      state_next.supS2   = cfgWord[srp_pkg::CFG_S2_SUP_BIT];
      state_next.supS1   = cfgWord[srp_pkg::CFG_S1_SUP_BIT];
      state_next.wideBus = !cfgWord[srp_pkg::CFG_NARROW_BUS_BIT];
    end
    state_next.rdValid = regRdEn;
    state_next.rdData  = '0;
    if (regRdEn && bankHit) begin
      case (regAddr)
        srp_pkg::SELFTEST_INFO_OFF: state_next.rdData = infoWord;
        srp_pkg::SOFT_RESET_OFF: begin
          state_next.rdData[srp_pkg::SOFT_RESET_BIT] = state_reg.softReset;
        end
        srp_pkg::PM_CAPS_OFF: state_next.rdData = capWord;
        default: state_next.rdData = '0;
      endcase
    end
    // Only the core is reset; this bank and the base address stay intact
    state_next.coreRstN = !state_next.softReset;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg           <= '0;
      state_reg.softReset <= srp_pkg::SOFT_RESET_RST;
      state_reg.wakeS2    <= srp_pkg::CFG_FIELD_RST;
      state_reg.wakeS1    <= srp_pkg::CFG_FIELD_RST;
      state_reg.supS2     <= srp_pkg::CFG_FIELD_RST;
      state_reg.supS1     <= srp_pkg::CFG_FIELD_RST;
      state_reg.wideBus   <= srp_pkg::CFG_FIELD_RST;
      state_reg.coreRstN  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdData  = state_reg.rdData;
  assign regRdValid = state_reg.rdValid;
  assign coreResetN = state_reg.coreRstN;

  a_tx_done_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    txSelftestDone |=> state_reg.txDone [*3])
    else $error("tx done not held");
  a_tx_fail_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    txSelftestDone && txSelftestFail |=> state_reg.txFail)
    else $error("tx fail not set");
  a_rx_done_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    rxSelftestDone |=> state_reg.rxDone)
    else $error("rx done not set");
  a_rx_fail_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    rxSelftestDone && rxSelftestFail |=> state_reg.rxFail)
    else $error("rx fail not set");
  a_fail_needs_done: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg.txFail |-> state_reg.txDone) and (state_reg.rxFail |-> state_reg.rxDone))
    else $error("fail bit without done");
  a_soft_reset_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    regWrEn && bankHit && regAddr == srp_pkg::SOFT_RESET_OFF
      |=> coreResetN == !$past(regWrData[srp_pkg::SOFT_RESET_BIT]))
    else $error("core reset does not follow soft reset bit");
  a_caps_fixed: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn && bankHit && regAddr == srp_pkg::PM_CAPS_OFF
      |=> regRdValid && !regRdData[15] && regRdData[14] && !regRdData[11])
    else $error("fixed capability bits wrong");
  a_no_eeprom_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    !eepromPresent && !state_reg.wideBus && !state_reg.supS1 && !state_reg.supS2
      |=> !state_reg.wideBus && !state_reg.supS1 && !state_reg.supS2)
    else $error("capability loaded without EEPROM");
  a_cfg_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgWordValid && eepromPresent && cfgWordAddr == srp_pkg::CFG_WORD_ADDR
      |=> state_reg.wideBus == !$past(cfgWord[srp_pkg::CFG_NARROW_BUS_BIT])
        && state_reg.supS2 == $past(cfgWord[srp_pkg::CFG_S2_SUP_BIT]))
    else $error("capability fields not loaded");
  a_cfg_wake_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgWordValid && eepromPresent && cfgWordAddr == srp_pkg::CFG_WORD_ADDR
      |=> state_reg.wakeS2 == $past(cfgWord[srp_pkg::CFG_WAKE_S2_BIT])
        && state_reg.wakeS1 == $past(cfgWord[srp_pkg::CFG_WAKE_S1_BIT])
        && state_reg.supS1 == $past(cfgWord[srp_pkg::CFG_S1_SUP_BIT]))
    else $error("wake capability fields not loaded");
  a_no_eeprom_wake: assert property (@(posedge clk_sys) disable iff (!resetn)
    !eepromPresent && !state_reg.wakeS2 && !state_reg.wakeS1
      |=> !state_reg.wakeS2 && !state_reg.wakeS1)
    else $error("wake capability loaded without EEPROM");
  a_cfg_other_word: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgWordValid && cfgWordAddr != srp_pkg::CFG_WORD_ADDR
      |=> $stable(state_reg.wakeS2) && $stable(state_reg.wakeS1)
        && $stable(state_reg.supS2) && $stable(state_reg.supS1)
        && $stable(state_reg.wideBus))
    else $error("capability changed by another word");
  // Software writes must never reach the capability fields
  a_caps_read_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cfgWordValid
      |=> $stable(state_reg.wakeS2) && $stable(state_reg.wakeS1)
        && $stable(state_reg.supS2) && $stable(state_reg.supS1)
        && $stable(state_reg.wideBus))
    else $error("capability changed without a load");
  a_tx_done_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    !txSelftestDone && !state_reg.txDone |=> !state_reg.txDone)
    else $error("tx done set without test end");
  a_rx_done_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rxSelftestDone && !state_reg.rxDone |=> !state_reg.rxDone)
    else $error("rx done set without test end");
  a_tx_fail_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !txSelftestDone && !state_reg.txFail |=> !state_reg.txFail)
    else $error("tx fail set without done");
  a_rx_fail_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rxSelftestDone && !state_reg.rxFail |=> !state_reg.rxFail)
    else $error("rx fail set without done");
  a_status_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg.txDone |=> state_reg.txDone) and (state_reg.txFail |=> state_reg.txFail)
      and (state_reg.rxDone |=> state_reg.rxDone)
      and (state_reg.rxFail |=> state_reg.rxFail))
    else $error("self-test status bit cleared");
  a_info_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn && bankHit && regAddr == srp_pkg::SELFTEST_INFO_OFF
      |=> regRdData[15:13] == 3'h0 && regRdData[10:5] == 6'h00
        && regRdData[2:0] == 3'h0)
    else $error("self-test reserved bits not zero");
  a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn && bankHit && regAddr == srp_pkg::SOFT_RESET_OFF
      |=> regRdData[15:1] == 15'h0000)
    else $error("reset control reserved bits not zero");
  a_caps_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn && bankHit && regAddr == srp_pkg::PM_CAPS_OFF
      |=> regRdData[8:1] == 8'h00)
    else $error("capability reserved bits not zero");
  a_read_valid: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn |=> regRdValid)
    else $error("read valid missing");
  a_read_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !regRdEn |=> !regRdValid && regRdData == 16'h0000)
    else $error("read data shown without a read");
  a_bank_miss_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    regRdEn && !bankHit |=> regRdData == 16'h0000)
    else $error("other bank read not zero");
  a_soft_reset_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    regWrEn && !(bankHit && regAddr == srp_pkg::SOFT_RESET_OFF)
      |=> state_reg.softReset == $past(state_reg.softReset))
    else $error("soft reset bit changed by other write");
  a_core_reset_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !regWrEn |=> $stable(coreResetN))
    else $error("core reset changed without a write");
endmodule

//--- core/srp_wake_gate.sv
`timescale 1ns/1ns
module srp_wake_gate (
  input  wire logic       clk_sys,          // System clock
  input  wire logic       resetn,           // Async reset, active low
  input  wire logic       wakeEvent,        // Wake signal from matcher
  input  wire logic [1:0] powerState,       // Current power state
  input  wire logic       powerEventEnable, // Software enable of power event
  input  wire logic       capWakeS1,        // Wake allowed in D1
  input  wire logic       capWakeS2,        // Wake allowed in D2
  output logic            powerEventOutN    // Power event pin, active low
);
  typedef struct packed {
    logic outN;
  } srp_wake_t;

  srp_wake_t state_reg;
  srp_wake_t state_next;
  logic      allowed;

  always_comb begin
    case (powerState)
      srp_pkg::PSTATE_D1: allowed = capWakeS1;
      srp_pkg::PSTATE_D2: allowed = capWakeS2;
      srp_pkg::PSTATE_D3: allowed = srp_pkg::CAP_WAKE_HOT3_VAL;
      default:            allowed = srp_pkg::CAP_WAKE_S0_VAL;
    endcase
    state_next.outN = !(wakeEvent && powerEventEnable && allowed);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{outN: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign powerEventOutN = state_reg.outN;

  a_wake_never_d0: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(powerState) == srp_pkg::PSTATE_D0 |-> powerEventOutN)
    else $error("power event asserted in D0");
  a_wake_d2_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(powerState) == srp_pkg::PSTATE_D2 && $past(wakeEvent)
      && $past(powerEventEnable) |-> powerEventOutN == !$past(capWakeS2))
    else $error("D2 wake gating wrong");
  a_wake_d1_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(powerState) == srp_pkg::PSTATE_D1 && $past(wakeEvent)
      && $past(powerEventEnable) |-> powerEventOutN == !$past(capWakeS1))
    else $error("D1 wake gating wrong");
  a_wake_d3_hot: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(powerState) == srp_pkg::PSTATE_D3 && $past(wakeEvent)
      && $past(powerEventEnable) |-> !powerEventOutN)
    else $error("hot D3 wake not signalled");
  a_wake_needs_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(powerEventEnable) || !$past(wakeEvent) |-> powerEventOutN)
    else $error("power event without enable and wake");
endmodule

//--- inc/srp_pkg.sv
package srp_pkg;
  localparam logic [3:0]  BANK_SEL          = 4'h3;
  localparam logic [3:0]  SELFTEST_INFO_OFF = 4'h4;
  localparam logic [3:0]  SOFT_RESET_OFF    = 4'h6;
  localparam logic [3:0]  PM_CAPS_OFF       = 4'h8;
  // Self-test info fields
  localparam int TX_DONE_BIT = 12;
  localparam int TX_FAIL_BIT = 11;
  localparam int RX_DONE_BIT = 4;
  localparam int RX_FAIL_BIT = 3;
  // Soft reset control field
  localparam int SOFT_RESET_BIT = 0;
  localparam logic SOFT_RESET_RST = 1'b0;
  // Capability word fields
  localparam int CAP_WAKE_COLD3_BIT = 15;
  localparam int CAP_WAKE_HOT3_BIT  = 14;
  localparam int CAP_WAKE_S2_BIT    = 13;
  localparam int CAP_WAKE_S1_BIT    = 12;
  localparam int CAP_WAKE_S0_BIT    = 11;
  localparam int CAP_S2_SUP_BIT     = 10;
  localparam int CAP_S1_SUP_BIT     = 9;
  localparam int CAP_WIDE_BUS_BIT   = 0;
  localparam logic CAP_WAKE_COLD3_VAL = 1'b0;
  localparam logic CAP_WAKE_HOT3_VAL  = 1'b1;
  localparam logic CAP_WAKE_S0_VAL    = 1'b0;
  // Positions inside the configuration parameter word (word 0x6)
  localparam logic [7:0] CFG_WORD_ADDR = 8'h06;
  localparam int CFG_WAKE_S2_BIT   = 5;
  localparam int CFG_WAKE_S1_BIT   = 4;
  localparam int CFG_S2_SUP_BIT    = 3;
  localparam int CFG_S1_SUP_BIT    = 2;
  localparam int CFG_NARROW_BUS_BIT = 0;
  localparam logic CFG_FIELD_RST = 1'b0;
  // Power states
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D1 = 2'h1;
  localparam logic [1:0] PSTATE_D2 = 2'h2;
  localparam logic [1:0] PSTATE_D3 = 2'h3;
endpackage

//--- tb/srp_cfg_loader_model.sv
`timescale 1ns/1ns
module srp_cfg_loader_model (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        present,    // EEPROM fitted on board
  input  wire logic        start,      // Send one word
  input  wire logic [7:0]  addrIn,     // Word address to send
  input  wire logic [15:0] wordIn,     // Word contents
  output logic             presentPin, // EEPROM-present pin level
  output logic             wordValid,  // Word strobe
  output logic [7:0]       wordAddr,   // Word address
  output logic [15:0]      wordOut     // Word data
);
  initial begin
    wordValid = 1'b0;
    wordAddr = 8'h00;
    wordOut = 16'h0000;
  end
  assign presentPin = present;
  always @(posedge clk_sys) begin
    wordValid <= start;
    if (start) begin
      wordAddr <= addrIn;
      wordOut <= wordIn;
    end else begin
      // Data is not held past the strobe
      wordOut <= ~wordOut;
    end
  end
endmodule

//--- tb/tb_srp_status_regs.sv
`timescale 1ns/1ns
module tb_srp_status_regs;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] bankSel = 4'h3;
  logic [3:0] regAddr = 4'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] regRdData;
  logic regRdValid;
  logic txDone = 1'b0;
  logic txFail = 1'b0;
  logic rxDone = 1'b0;
  logic rxFail = 1'b0;
  logic present = 1'b0;
  logic ldStart = 1'b0;
  logic [7:0] ldAddr = 8'h00;
  logic [15:0] ldWord = 16'h0000;
  logic presentPin;
  logic cfgValid;
  logic [7:0] cfgAddr;
  logic [15:0] cfgWord;
  logic wakeEvent = 1'b0;
  logic [1:0] powerState = 2'h0;
  logic powerEventEnable = 1'b0;
  logic coreResetN;
  logic powerEventOutN;
  int err_count = 0;
  int n_checks = 0;

  always #50 clk_sys = ~clk_sys;

  srp_cfg_loader_model i_srp_cfg_loader_model (.clk_sys(clk_sys), .present(present),
    .start(ldStart), .addrIn(ldAddr), .wordIn(ldWord), .presentPin(presentPin),
    .wordValid(cfgValid), .wordAddr(cfgAddr), .wordOut(cfgWord));

  srp_status_regs i_srp_status_regs (.clk_sys(clk_sys), .resetn(resetn), .bankSel(bankSel),
    .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .txSelftestDone(txDone),
    .txSelftestFail(txFail), .rxSelftestDone(rxDone), .rxSelftestFail(rxFail),
    .eepromPresentPin(presentPin), .cfgWordValid(cfgValid), .cfgWordAddr(cfgAddr),
    .cfgWord(cfgWord), .wakeEvent(wakeEvent), .powerState(powerState),
    .powerEventEnable(powerEventEnable), .coreResetN(coreResetN),
    .powerEventOutN(powerEventOutN));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Mask hides the bus width bit where it carries no meaning
  task automatic rdChk(input logic [3:0] bk, input logic [3:0] ad, input logic [15:0] exp,
                       input logic [15:0] msk);
    @(posedge clk_sys);
    bankSel <= bk;
    regAddr <= ad;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0, regRdValid});
    chk("read data", exp, regRdData & msk);
    @(posedge clk_sys);
    #1;
    chk("read valid end", 16'h0000, {15'h0, regRdValid});
    chk("read data end", 16'h0000, regRdData);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    bankSel <= 4'h3;
    regAddr <= ad;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    #1;
  endtask

  task automatic ld(input logic [7:0] ad, input logic [15:0] w);
    @(posedge clk_sys);
    ldStart <= 1'b1;
    ldAddr <= ad;
    ldWord <= w;
    @(posedge clk_sys);
    ldStart <= 1'b0;
  endtask

  task automatic pw(input logic [1:0] st, input logic wk, input logic en, input logic exp);
    @(posedge clk_sys);
    powerState <= st;
    wakeEvent <= wk;
    powerEventEnable <= en;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("power event", {15'h0, exp}, {15'h0, powerEventOutN});
  endtask

  task automatic pwAll(input logic wakeCaps);
    for (int s = 0; s < 4; s++) begin
      pw(2'(s), 1'b1, 1'b1, !(s == 3 || (s != 0 && wakeCaps)));
    end
    pw(srp_pkg::PSTATE_D3, 1'b1, 1'b0, 1'b1);
    pw(srp_pkg::PSTATE_D3, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rdChk(4'h3, srp_pkg::SELFTEST_INFO_OFF, 16'h0000, 16'hffff);
    rdChk(4'h3, srp_pkg::SOFT_RESET_OFF, 16'h0000, 16'hffff);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h4000, 16'hfffe);
    // Fail without done must not stick
    @(posedge clk_sys);
    rxFail <= 1'b1;
    @(posedge clk_sys);
    rxFail <= 1'b0;
    txDone <= 1'b1;
    txFail <= 1'b1;
    rxDone <= 1'b1;
    @(posedge clk_sys);
    txDone <= 1'b0;
    txFail <= 1'b0;
    rxDone <= 1'b0;
    rdChk(4'h3, srp_pkg::SELFTEST_INFO_OFF, 16'h1810, 16'hffff);
    wr(srp_pkg::SELFTEST_INFO_OFF, 16'hffff);
    rdChk(4'h3, srp_pkg::SELFTEST_INFO_OFF, 16'h1810, 16'hffff);
    wr(srp_pkg::SOFT_RESET_OFF, 16'h0001);
    chk("core reset", 16'h0000, {15'h0, coreResetN});
    rdChk(4'h3, srp_pkg::SOFT_RESET_OFF, 16'h0001, 16'hffff);
    rdChk(4'h3, srp_pkg::SELFTEST_INFO_OFF, 16'h1810, 16'hffff);
    chk("core reset held", 16'h0000, {15'h0, coreResetN});
    wr(srp_pkg::SOFT_RESET_OFF, 16'hfffe);
    chk("core reset", 16'h0001, {15'h0, coreResetN});
    rdChk(4'h3, srp_pkg::SOFT_RESET_OFF, 16'h0000, 16'hffff);
    rdChk(4'h3, 4'ha, 16'h0000, 16'hffff);
    rdChk(4'h2, srp_pkg::PM_CAPS_OFF, 16'h0000, 16'hffff);
    wr(srp_pkg::PM_CAPS_OFF, 16'hbdff);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h4000, 16'hfffe);
    ld(srp_pkg::CFG_WORD_ADDR, 16'h003d);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h4000, 16'hfffe);
    pwAll(1'b0);
    @(posedge clk_sys);
    present <= 1'b1;
    repeat (6) @(posedge clk_sys);
    ld(8'h05, 16'h003d);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h4000, 16'hfffe);
    ld(srp_pkg::CFG_WORD_ADDR, 16'h003d);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h7600, 16'hffff);
    pwAll(1'b1);
    ld(srp_pkg::CFG_WORD_ADDR, 16'h0000);
    rdChk(4'h3, srp_pkg::PM_CAPS_OFF, 16'h4001, 16'hffff);
    pwAll(1'b0);
    @(posedge clk_sys);
    rxDone <= 1'b1;
    rxFail <= 1'b1;
    @(posedge clk_sys);
    rxDone <= 1'b0;
    rxFail <= 1'b0;
    rdChk(4'h3, srp_pkg::SELFTEST_INFO_OFF, 16'h1818, 16'hffff);
    results();
  end
endmodule
